/* acc_pkg.sv */
`default_nettype none
package acc_pkg;
  localparam int RES_W = 12;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  // Conversion times and result lead time before busy falls
  localparam int CLK_PERIOD_PS = 25000;
  localparam int CONV12_TIME_NS = 20000;
  localparam int CONV8_TIME_NS = 13000;
  localparam int DATA_LEAD_NS = 400;
  localparam int CONV12_CYC = (CONV12_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int CONV8_CYC = (CONV8_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int LEAD_CYC = (DATA_LEAD_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;
  localparam logic [NIB_W-1:0] PAD_ZERO = 4'h0;
  localparam logic [2:0] SHORT_LOW3 = 3'h0;
  localparam logic SHORT_BIT3 = 1'b1;

  typedef struct packed {
    logic chip_en;
    logic chip_sel_n;
    logic read_conv;
    logic word_sel;
    logic byte_short_select;
  } acc_ctrl_t;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_CONV = 2'b01,
    ACC_LEAD = 2'b11
  } acc_state_t;
endpackage : acc_pkg
`default_nettype wire

/* acc_sync.sv */
`default_nettype none
module acc_sync
  import acc_pkg::*;
#(
  parameter int W = 5
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // Reset loads a fixed idle pattern from the caller, a constant there
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= rst_val_i;
      q_ff <= rst_val_i;
    end
    else
    begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule : acc_sync
`default_nettype wire

/* acc_conv_ctrl.sv */
`default_nettype none
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int CONV12_CYCLES = CONV12_CYC,
  parameter int CONV8_CYCLES = CONV8_CYC,
  parameter int LEAD_CYCLES = LEAD_CYC
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CHIP_EN_I,
  input wire logic CHIP_SEL_N_I,
  input wire logic READ_CONV_I,
  input wire logic WORD_SEL_I,
  input wire logic BYTE_SHORT_SELECT_I,
  input wire logic [RES_W-1:0] SAR_RESULT_I,
  output logic SAMPLE_O,
  output logic BUSY_FLAG_O,
  output logic [RES_W-1:0] RESULT_BITS_O,
  output logic [RES_W-1:0] RESULT_BITS_OE_O
);
  //////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  acc_ctrl_t pins_raw;
  acc_ctrl_t pins_s;
  acc_ctrl_t idle_pins;

  always_comb
  begin
    pins_raw.chip_en = CHIP_EN_I;
    pins_raw.chip_sel_n = CHIP_SEL_N_I;
    pins_raw.read_conv = READ_CONV_I;
    pins_raw.word_sel = WORD_SEL_I;
    pins_raw.byte_short_select = BYTE_SHORT_SELECT_I;
  end

  // Idle as deselected with read/convert high, so reset never starts work
  always_comb
  begin
    idle_pins.chip_en = 1'b0;
    idle_pins.chip_sel_n = 1'b1;
    idle_pins.read_conv = 1'b1;
    idle_pins.word_sel = 1'b1;
    idle_pins.byte_short_select = 1'b0;
  end

  acc_sync #(.W($bits(acc_ctrl_t))) u_sync
  (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .d_i(pins_raw),
    .rst_val_i(idle_pins),
    .q_o(pins_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // Start detection
  logic start_ok;
  logic start_ok_ff;
  logic start_evt;
  logic read_ok;

  // All three in start state; the last to arrive makes the edge
  assign start_ok = pins_s.chip_en && !pins_s.chip_sel_n
                    && !pins_s.read_conv;
  assign read_ok = pins_s.chip_en && !pins_s.chip_sel_n
                   && pins_s.read_conv;

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      start_ok_ff <= 1'b0;
    else
      start_ok_ff <= start_ok;
  end

  // Covers CE rise, CS fall and R/C fall alike
  assign start_evt = start_ok && !start_ok_ff;

  //////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  acc_state_t state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic short_ff;
  logic [RES_W-1:0] result_ff;

  function automatic logic [CNT_W-1:0] conv_len(input logic short_cyc);
    logic [CNT_W-1:0] n;
    n = short_cyc ? CNT_W'(CONV8_CYCLES) : CNT_W'(CONV12_CYCLES);
    return n - CNT_W'(LEAD_CYCLES);
  endfunction : conv_len

  function automatic logic cnt_last(input logic [CNT_W-1:0] c);
    return (c <= CNT_W'(1));
  endfunction : cnt_last

  // State walk; the counter below decides when each phase ends
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      state_ff <= ACC_IDLE;
    else
    begin
      unique case (state_ff)
        ACC_IDLE:
        begin
          if (start_evt)
            state_ff <= ACC_CONV;
        end
        ACC_CONV:
        begin
          // Start events here are ignored by design
          if (cnt_last(cnt_ff))
            state_ff <= ACC_LEAD;
        end
        ACC_LEAD:
        begin
          // Result already stored; busy holds for the lead time
          if (cnt_last(cnt_ff))
            state_ff <= ACC_IDLE;
        end
        default:
          state_ff <= ACC_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      cnt_ff <= '0;
    else
    begin
      unique case (state_ff)
        ACC_IDLE:
        begin
          if (start_evt)
            cnt_ff <= conv_len(pins_s.byte_short_select);
        end
        ACC_CONV:
        begin
          if (cnt_last(cnt_ff))
            cnt_ff <= CNT_W'(LEAD_CYCLES);
          else
            cnt_ff <= cnt_ff - CNT_W'(1);
        end
        ACC_LEAD:
        begin
          // Held once expired so a stray count never wraps
          if (!cnt_last(cnt_ff))
            cnt_ff <= cnt_ff - CNT_W'(1);
        end
        default:
          cnt_ff <= '0;
      endcase
    end
  end

  // Short-cycle choice latched once; later starts are ignored while busy
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      short_ff <= 1'b0;
    else if (state_ff == ACC_IDLE && start_evt)
      short_ff <= pins_s.byte_short_select;
  end

  // Short results carry a fixed pattern in the low nibble
  function automatic logic [RES_W-1:0] capture_word(
    input logic short_cyc,
    input logic [RES_W-1:0] sar
  );
    logic [RES_W-1:0] w;
    w = sar;
    if (short_cyc)
      w = {sar[RES_W-1:NIB_W], SHORT_BIT3, SHORT_LOW3};
    return w;
  endfunction : capture_word

  // Result captured at end of bit trials, ahead of busy falling
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      result_ff <= '0;
    else if (state_ff == ACC_CONV && cnt_last(cnt_ff))
      result_ff <= capture_word(short_ff, SAR_RESULT_I);
  end

  assign BUSY_FLAG_O = (state_ff != ACC_IDLE);
  assign SAMPLE_O = (state_ff == ACC_IDLE) && start_evt;

  //////////////////////////////////////////////////////////////////////////
  // Output buffers
  logic [RES_W-1:0] nxt_out;
  logic [RES_W-1:0] nxt_oe;
  logic [RES_W-1:0] out_ff;
  logic [RES_W-1:0] oe_ff;
  logic drive_ok;

  // Floats at R/C fall and during busy; old data shown while R/C high
  assign drive_ok = read_ok && !BUSY_FLAG_O
                    && !start_evt;

  // Both bytes ride the upper lanes, left-justified
  function automatic logic [RES_W-1:0] byte_data(
    input logic low_byte,
    input logic [RES_W-1:0] res
  );
    logic [RES_W-1:0] d;
    if (low_byte)
      d = {res[NIB_W-1:0], PAD_ZERO, PAD_ZERO};
    else
      d = {res[RES_W-1:NIB_W], PAD_ZERO};
    return d;
  endfunction : byte_data

  // Byte picked live from the pin, as a bus address bit would be
  always_comb
  begin
    nxt_out = result_ff;
    if (!pins_s.word_sel)
      nxt_out = byte_data(pins_s.byte_short_select, result_ff);
  end

  always_comb
  begin
    nxt_oe = '0;
    if (drive_ok)
    begin
      if (pins_s.word_sel)
        nxt_oe = '1;
      else
        nxt_oe = {{BYTE_W{1'b1}}, {NIB_W{1'b0}}};
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      out_ff <= '0;
    else
      out_ff <= nxt_out;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      oe_ff <= '0;
    else
      oe_ff <= nxt_oe;
  end

  assign RESULT_BITS_O = out_ff;
  assign RESULT_BITS_OE_O = oe_ff;
endmodule : acc_conv_ctrl
`default_nettype wire

/* acc_conv_ctrl_props.sv */
`default_nettype none
module acc_props
  import acc_pkg::*;
#(
  parameter int CONV12_CYCLES = CONV12_CYC,
  parameter int CONV8_CYCLES = CONV8_CYC
)
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CHIP_EN_I,
  input wire logic CHIP_SEL_N_I,
  input wire logic READ_CONV_I,
  input wire logic BYTE_SHORT_SELECT_I,
  input wire logic SAMPLE_O,
  input wire logic BUSY_FLAG_O,
  input wire logic [RES_W-1:0] RESULT_BITS_OE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CNT_W-1:0] len_ff;
  logic bs_ff;
  wire logic sel_w = CHIP_EN_I & ~CHIP_SEL_N_I;
  wire logic rd_w = sel_w & READ_CONV_I;
  wire logic cv_w = sel_w & ~READ_CONV_I;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I || !BUSY_FLAG_O)
      len_ff <= '0;
    else
      len_ff <= len_ff + CNT_W'(1);
  end
  // Pins reach the core two edges late
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SAMPLE_O)
      bs_ff <= $past(BYTE_SHORT_SELECT_I, 2);
  end
  chk_busy_quiet: assert property
    (BUSY_FLAG_O |-> RESULT_BITS_OE_O == '0)
    else $error("outputs driven while busy");
  chk_start_ignored: assert property (BUSY_FLAG_O |-> !SAMPLE_O)
    else $error("start taken while busy");
  chk_start_busy: assert property (SAMPLE_O |=> BUSY_FLAG_O[*2])
    else $error("busy missing after start");
  chk_start_float: assert property
    (SAMPLE_O |=> RESULT_BITS_OE_O == '0)
    else $error("outputs not floated at start");
  chk_conv_len: assert property
    ($fell(BUSY_FLAG_O) |-> len_ff ==
    (bs_ff ? CNT_W'(CONV8_CYCLES) : CNT_W'(CONV12_CYCLES)))
    else $error("wrong conversion length");
  chk_oe_shape: assert property
    (RESULT_BITS_OE_O inside {12'h000, 12'hfff, 12'hff0})
    else $error("bad output enable group");
  chk_read_cond: assert property
    ($rose(|RESULT_BITS_OE_O) |-> $past(rd_w, 3) || $past(rd_w, 4))
    else $error("read without select");
  chk_start_cond: assert property
    (SAMPLE_O |-> $past(cv_w, 2) || $past(cv_w, 3))
    else $error("start without select");
  chk_reset_idle: assert property
    (disable iff (1'b0) RST_I |=>
    !BUSY_FLAG_O && RESULT_BITS_OE_O == '0) else $error("not idle in reset");
endmodule : acc_props
bind acc_conv_ctrl acc_props #(
  .CONV12_CYCLES(CONV12_CYCLES),
  .CONV8_CYCLES(CONV8_CYCLES)
) acc_props_i (
  .CORE_CLK_I(CORE_CLK_I),
  .RST_I(RST_I),
  .CHIP_EN_I(CHIP_EN_I),
  .CHIP_SEL_N_I(CHIP_SEL_N_I),
  .READ_CONV_I(READ_CONV_I),
  .BYTE_SHORT_SELECT_I(BYTE_SHORT_SELECT_I),
  .SAMPLE_O(SAMPLE_O),
  .BUSY_FLAG_O(BUSY_FLAG_O),
  .RESULT_BITS_OE_O(RESULT_BITS_OE_O)
);
`default_nettype wire

/* acc_host.sv */
`default_nettype none
module acc_host
  import acc_pkg::*;
(
  input wire logic clk_i,
  output var acc_ctrl_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins_o = 5'h0e;
  // Each level stands 7 cycles, over both pulse minimums
  task automatic drive(input acc_ctrl_t c);
    @(negedge clk_i);
    pins_o = c;
    repeat (6) @(negedge clk_i);
  endtask : drive
endmodule : acc_host
`default_nettype wire

/* acc_conv_ctrl_test.sv */
`default_nettype none
module acc_conv_ctrl_test;
  import acc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic smp, busy, seen = 1'b0;
  logic [RES_W-1:0] sar = '0, res, oe, r;
  acc_ctrl_t pins;
  logic [23:0] q[$];
  int err_total = 0, checks_done = 0, starts = 0, samples = 0, cyc = 0;
  integer seed = 32'h42ca3a6d;
  always #12.5 clk = ~clk;
  acc_host acc_host_i (.clk_i(clk), .pins_o(pins));
  acc_conv_ctrl #(.CONV12_CYCLES(40), .CONV8_CYCLES(30), .LEAD_CYCLES(8))
  acc_conv_ctrl_i (
    .CORE_CLK_I(clk), .RST_I(rst), .CHIP_EN_I(pins.chip_en),
    .CHIP_SEL_N_I(pins.chip_sel_n), .READ_CONV_I(pins.read_conv),
    .WORD_SEL_I(pins.word_sel), .BYTE_SHORT_SELECT_I(pins.byte_short_select),
    .SAR_RESULT_I(sar), .SAMPLE_O(smp), .BUSY_FLAG_O(busy),
    .RESULT_BITS_O(res), .RESULT_BITS_OE_O(oe));
  task cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // Pin order: CE CS_N RC WS BS; src picks the last pin to move
  task automatic conv(input int src, input logic bs);
    r = 12'($random(seed));
    sar = r;
    if (bs)
      r[3:0] = 4'h8;
    acc_host_i.drive((src == 0 ? 5'h16 : src == 1 ? 5'h02 : 5'h1a) | bs);
    q.push_back({12'hfff, r});
    acc_host_i.drive(5'h12 | bs);
    starts++;
    acc_host_i.drive(5'h16 | bs);
    acc_host_i.drive(5'h12 | bs);
    acc_host_i.drive(5'h16 | bs);
    for (int i = 0; i < 100 && busy !== 1'b0; i++)
      @(negedge clk);
    repeat (6) @(negedge clk);
  endtask : conv
  // Deselect first so each byte shows as a fresh read
  task automatic rd(input logic bs);
    acc_host_i.drive(5'h1c | bs);
    q.push_back({12'hff0, bs ? {r[3:0], 8'h0} : {r[11:4], 4'h0}});
    acc_host_i.drive(5'h14 | bs);
  endtask : rd
  always @(negedge clk)
  begin
    if (smp === 1'b1)
      samples++;
    if ((|oe) === 1'b1 && !seen)
      cmp("result", q.size() ? q.pop_front() : 24'hx, {oe, res & oe});
    seen = ((|oe) === 1'b1);
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      test_done();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    // First conversion opens with a read of the cleared result
    q.push_back({12'hfff, 12'h000});
    conv(0, 1'b0);
    conv(1, 1'b1);
    conv(2, 1'b0);
    rd(1'b0);
    rd(1'b1);
    for (int i = 0; i < 3; i++)
      conv(i, 1'($random(seed)));
    conv(0, 1'b1);
    rd(1'b0);
    rd(1'b1);
    conv(0, 1'b0);
    cmp("starts", 24'(starts), 24'(samples));
    cmp("pending", 24'h0, 24'(q.size()));
    test_done();
  end
endmodule : acc_conv_ctrl_test
`default_nettype wire
